// ### hw/spf_sequencer.sv
// How it works
// - Erase armed by pattern, store within four cycles
// - Boot-side erase halts CPU; app erase doesn't
// - Load stores data word at word field
// - Buffer clears on write, re-enable, reset
// - EEPROM write discards partly loaded buffer
// - Write armed by pattern, store within four
// - Boot-side write halts CPU; app write doesn't
// - Interrupt held while store enable reads zero
// - App-side erase/write blocks app section, busy flag set
// - Re-enable command clears busy flag
// - Lock command programs lock bits 5..2 zeroed in data
// - Lock programming blocks no section
// - EEPROM busy blocks programming and fuse reads
// - Armed load at pointer one returns lock
// - Lock-set and store enable self-clear
// - Pointer zero/three return fuse low/high
// - Programmed bits read zero, unprogrammed one
// - Reset does not abort running erase/write
// - Store enable clears after store or timeout
// - Invalid command patterns arm nothing but still update interrupt enable
// - Control register bit layout, bit 5 zero
// - Buffer load clears the busy flag
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`include "spf_map.svh"
`default_nettype none

module spf_sequencer
  import spf_pkg::*;
#(
  parameter int PAGE_WORDS = 32,
  parameter int OP_CYCLES  = `SPF_OP_TIME_NS * `SPF_CLK_MHZ / 1000
) (
  // Clock and resets
  input  wire logic           core_clk,
  input  wire logic           resetn,
  input  wire logic           por_n,
  // Avalon-MM slave
  input  wire logic [3:0]     avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire logic [31:0]    avs_writedata,
  input  wire logic [3:0]     avs_byteenable,
  output var  logic [31:0]    avs_readdata,
  output var  logic           avs_waitrequest,
  // CPU core
  input  wire spf_cpu_req_t   cpu_req,
  output var  logic           cpu_load_taken,
  output var  logic [7:0]     cpu_load_data,
  output var  logic           cpu_halt,
  output var  logic           app_read_block,
  output var  logic           irq,
  // EEPROM controller
  input  wire logic           eeprom_write_busy,
  input  wire logic           eeprom_write_start,
  // Nonvolatile bytes
  input  wire logic [7:0]     fuse_low_byte,
  input  wire logic [7:0]     fuse_high_byte,
  input  wire logic [7:0]     lock_init,
  // Flash array
  output var  spf_flash_cmd_t flash_cmd,
  output var  logic           flash_busy,
  input  wire logic [$clog2(PAGE_WORDS)-1:0] buf_idx,
  output var  logic [15:0]    buf_word
);

  localparam int IW = $clog2(PAGE_WORDS);
  // Reset image of the control register
  localparam logic [7:0] CTRL_RST = `SPF_CTRL_RST;

  // ========================================
  // Reset synchronisers
  logic sys_ff1_reg;
  logic sys_ff2_reg;
  logic por_ff1_reg;
  logic por_ff2_reg;

  // Asserts at once, releases on the second edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sys_ff1_reg <= 1'b0;
      sys_ff2_reg <= 1'b0;
    end else begin
      sys_ff1_reg <= 1'b1;
      sys_ff2_reg <= sys_ff1_reg;
    end
  end

  // Separate power reset so a system reset leaves a write running
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      por_ff1_reg <= 1'b0;
      por_ff2_reg <= 1'b0;
    end else begin
      por_ff1_reg <= 1'b1;
      por_ff2_reg <= por_ff1_reg;
    end
  end

  wire logic rst_n = sys_ff2_reg;
  wire logic pr_n  = por_ff2_reg;

  // ========================================
  // State declarations
  logic                  irq_en_reg;
  logic [4:0]            cmd_reg;
  logic [2:0]            win_reg;
  logic                  sec_busy_reg;
  spf_op_t               op_reg;
  logic [19:0]           op_cnt_reg;
  logic                  op_boot_reg;
  logic [7:0]            lock_reg;
  logic                  lock_loaded_reg;
  logic                  wait_reg;
  logic [PAGE_WORDS-1:0] loaded_reg;
  logic [15:0]           mem_reg [PAGE_WORDS];

  // ========================================
  // Decode of bus and instructions
  wire logic       bus_req  = avs_read | avs_write;
  wire logic       bus_take = bus_req & ~wait_reg;
  wire logic       op_idle  = (op_reg == SPF_OP_IDLE);
  wire logic [4:0] wr_cmd   = avs_writedata[4:0];
  wire logic [6:0] ptr_page =
    cpu_req.ptr[`SPF_PAGE_MSB:`SPF_PAGE_LSB];
  wire logic [IW-1:0] ptr_word =
    cpu_req.ptr[`SPF_WORD_LSB +: IW];

  // Only the five listed patterns arm anything
  // pattern check
  logic cmd_valid;
  always_comb begin
    cmd_valid = (wr_cmd == `SPF_CMD_LOAD)  |
                (wr_cmd == `SPF_CMD_ERASE) |
                (wr_cmd == `SPF_CMD_WRITE) |
                (wr_cmd == `SPF_CMD_LOCK)  |
                (wr_cmd == `SPF_CMD_REEN);
  end

  // Bad pattern still updates the interrupt enable
  wire logic ctrl_wr = bus_take & avs_write & avs_byteenable[0] &
                       (avs_address == `SPF_OFF_CTRL);
  // A running op refuses re-enable as well
  // arming refused while EEPROM writes
  wire logic arm = ctrl_wr & cmd_valid & ~eeprom_write_busy & op_idle;

  // Store taken at counts 4..1, load at 4..2
  // store inside the window
  wire logic st_go = cpu_req.store & cmd_reg[0] & (win_reg != 3'h0) &
                     ~eeprom_write_busy & op_idle;
  wire logic ld_go = cpu_req.load & (cmd_reg == `SPF_CMD_LOCK) &
                     (win_reg >= `SPF_LOAD_WIN_MIN) &
                     ~eeprom_write_busy & op_idle;

  wire logic go_load  = st_go & (cmd_reg == `SPF_CMD_LOAD);
  wire logic go_erase = st_go & (cmd_reg == `SPF_CMD_ERASE);
  wire logic go_write = st_go & (cmd_reg == `SPF_CMD_WRITE);
  wire logic go_lock  = st_go & (cmd_reg == `SPF_CMD_LOCK);
  wire logic go_reen  = st_go & (cmd_reg == `SPF_CMD_REEN);
  wire logic op_done  = ~op_idle & (op_cnt_reg == 20'h0);
  wire logic wr_done  = op_done & (op_reg == SPF_OP_WRITE);

  // Bits as seen by software while an operation is running
  wire logic st_en_vis = cmd_reg[0] | ~op_idle;
  wire logic erase_vis = cmd_reg[1] | (op_reg == SPF_OP_ERASE);
  wire logic write_vis = cmd_reg[2] | (op_reg == SPF_OP_WRITE);

  // ========================================
  // Control register and arming window
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= CTRL_RST[`SPF_BIT_IRQ_EN];
      cmd_reg    <= `SPF_CMD_NONE;
      win_reg    <= 3'h0;
    end else begin
      if (ctrl_wr)
        irq_en_reg <= avs_writedata[`SPF_BIT_IRQ_EN];
      if (arm) begin
        cmd_reg <= wr_cmd;
        win_reg <= `SPF_STORE_WIN;
      end else if (st_go | ld_go) begin
        // clear after lock read or store
        cmd_reg <= `SPF_CMD_NONE;
        win_reg <= 3'h0;
      end else if (win_reg != 3'h0) begin
        win_reg <= win_reg - 3'h1;
        if (win_reg == 3'h1)
          cmd_reg <= `SPF_CMD_NONE;
      end
    end
  end

  // ========================================
  // Section busy flag
  // Set listed first; one command never sets and clears
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_busy_reg <= 1'b0;
    end else if ((go_erase | go_write) &&
                 ptr_page < `SPF_BOOT_FIRST_PAGE) begin
      sec_busy_reg <= 1'b1;
    end else if (go_load | go_reen) begin
      sec_busy_reg <= 1'b0;
    end
  end

  // ========================================
  // Page erase and write timer
  // Timer spans OP_CYCLES edges from the start
  // power reset only, system reset ignored
  always_ff @(posedge core_clk or negedge pr_n) begin
    if (!pr_n) begin
      op_reg      <= SPF_OP_IDLE;
      op_cnt_reg  <= 20'h0;
      op_boot_reg <= 1'b0;
      flash_cmd   <= '0;
    end else begin
      // Start strobes last one cycle
      flash_cmd.erase <= 1'b0;
      flash_cmd.write <= 1'b0;
      if (go_erase | go_write) begin
        op_reg          <= go_erase ? SPF_OP_ERASE : SPF_OP_WRITE;
        op_cnt_reg      <= 20'(OP_CYCLES - 1);
        op_boot_reg     <= (ptr_page >= `SPF_BOOT_FIRST_PAGE);
        flash_cmd.erase <= go_erase;
        flash_cmd.write <= go_write;
        flash_cmd.page  <= ptr_page;
      end else if (op_done) begin
        op_reg      <= SPF_OP_IDLE;
        op_boot_reg <= 1'b0;
      end else if (!op_idle) begin
        op_cnt_reg <= op_cnt_reg - 20'h1;
      end
    end
  end

  // ========================================
  // Lock bits, kept over system reset
  // Bits only ever fall from one to zero
  // No timer: the bits change at once
  always_ff @(posedge core_clk or negedge pr_n) begin
    if (!pr_n) begin
      lock_reg        <= `SPF_LOCK_RST;
      lock_loaded_reg <= 1'b0;
    end else if (!lock_loaded_reg) begin
      lock_reg        <= lock_init;
      lock_loaded_reg <= 1'b1;
    end else if (go_lock) begin
      lock_reg <= lock_reg & {2'b11, cpu_req.data[5:2], 2'b11};
    end
  end

  // ========================================
  // Temporary page buffer
  // System reset wipes it too, even under a write
  // EEPROM write drops a partial load
  wire logic buf_clr = wr_done | go_reen |
                       (eeprom_write_start & (|loaded_reg));

  for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_buf
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        loaded_reg[i] <= 1'b0;
        mem_reg[i]    <= 16'hffff;
      end else if (go_load && ptr_word == IW'(i) && !loaded_reg[i]) begin
        // A load in the clearing cycle keeps its word
        // word stored at word field
        // loaded word refuses a second load
        loaded_reg[i] <= 1'b1;
        mem_reg[i]    <= cpu_req.data;
      end else if (buf_clr) begin
        loaded_reg[i] <= 1'b0;
        mem_reg[i]    <= 16'hffff;
      end
    end
  end

  // Word follows buf_idx one cycle later
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      buf_word <= 16'hffff;
    else
      buf_word <= mem_reg[buf_idx];
  end

  // ========================================
  // Fuse and lock readback
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_load_taken <= 1'b0;
      cpu_load_data  <= 8'h00;
    end else begin
      cpu_load_taken <= ld_go;
      if (ld_go) begin
        unique case (cpu_req.ptr)
          `SPF_PTR_FUSE_LO: cpu_load_data <= fuse_low_byte;
          `SPF_PTR_LOCK:    cpu_load_data <= lock_reg;
          `SPF_PTR_FUSE_HI: cpu_load_data <= fuse_high_byte;
          // Unknown pointers read as all unprogrammed
          default:          cpu_load_data <= 8'hff;
        endcase
      end
    end
  end

  // ========================================
  // Core-facing status outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halt       <= 1'b0;
      app_read_block <= 1'b0;
      flash_busy     <= 1'b0;
      irq            <= 1'b0;
    end else begin
      // Halt and busy trail the start strobe by a cycle
      // boot-side erase halts the core
      cpu_halt       <= ~op_idle & op_boot_reg & ~op_done;
      app_read_block <= sec_busy_reg;
      flash_busy     <= ~op_idle & ~op_done;
      // Level; a new arming or clearing the interrupt enable drops it
      // level request while store enable low
      irq            <= irq_en_reg & ~st_en_vis;
    end
  end

  // ========================================
  // Avalon slave: one wait cycle per access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg     <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      // Idle high, so every request sees one wait state
      wait_reg <= ~(bus_req & wait_reg);
      // Read data is built in the wait cycle
      if (bus_req && wait_reg && avs_read) begin
        unique case (avs_address)
          `SPF_OFF_CTRL: avs_readdata <= {24'h0, irq_en_reg,
                            sec_busy_reg, 1'b0, cmd_reg[4],
                            cmd_reg[3], write_vis, erase_vis,
                            st_en_vis};
          `SPF_OFF_STAT: avs_readdata <= {28'h0, |loaded_reg,
                            eeprom_write_busy, op_boot_reg,
                            ~op_idle};
          `SPF_OFF_LOCK: avs_readdata <= {24'h0, lock_reg};
          default:       avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  assign avs_waitrequest = wait_reg;

endmodule
`default_nettype wire

// ### hw/spf_map.svh
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH

// ========================================
// Register byte offsets
`define SPF_OFF_CTRL        4'h0
`define SPF_OFF_STAT        4'h4
`define SPF_OFF_LOCK        4'h8

// ========================================
// Control register fields
`define SPF_BIT_IRQ_EN      7
`define SPF_BIT_SEC_BUSY    6
`define SPF_BIT_REEN        4
`define SPF_BIT_LOCK_SET    3
`define SPF_BIT_PG_WRITE    2
`define SPF_BIT_PG_ERASE    1
`define SPF_BIT_STORE_EN    0
`define SPF_CTRL_RST        8'h00

// ========================================
// Command patterns in the low five bits
`define SPF_CMD_NONE        5'h00
`define SPF_CMD_LOAD        5'h01
`define SPF_CMD_ERASE       5'h03
`define SPF_CMD_WRITE       5'h05
`define SPF_CMD_LOCK        5'h09
`define SPF_CMD_REEN        5'h11

// ========================================
// Pointer fields and special pointer values
`define SPF_PTR_FUSE_LO     16'h0000
`define SPF_PTR_LOCK        16'h0001
`define SPF_PTR_FUSE_HI     16'h0003
`define SPF_PAGE_LSB        6
`define SPF_PAGE_MSB        12
`define SPF_WORD_LSB        1
`define SPF_BOOT_FIRST_PAGE 7'h60
`define SPF_LOCK_RST        8'hff

// ========================================
// Timing
`define SPF_STORE_WIN       3'h4
`define SPF_LOAD_WIN_MIN    3'h2
`define SPF_OP_TIME_NS      3700000
`define SPF_CLK_MHZ         250

`endif

// ### hw/spf_pkg.sv
`default_nettype none
package spf_pkg;

  typedef enum logic [1:0] {
    SPF_OP_IDLE,
    SPF_OP_ERASE,
    SPF_OP_WRITE
  } spf_op_t;

  // One instruction from the core, with its operands
  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] ptr;
    logic [15:0] data;
  } spf_cpu_req_t;

  // Command towards the Flash array
  typedef struct packed {
    logic       erase;
    logic       write;
    logic [6:0] page;
  } spf_flash_cmd_t;

endpackage
`default_nettype wire

// ### bench/spf_seq_properties.sv
`include "spf_map.svh"
`default_nettype none
module spf_seq_properties
  import spf_pkg::*;
(
  // Clock and reset
  input wire logic           core_clk,
  input wire logic           resetn,
  // Bus handshake
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic           avs_waitrequest,
  // Core side
  input wire spf_cpu_req_t   cpu_req,
  input wire logic           cpu_load_taken,
  input wire logic [7:0]     cpu_load_data,
  input wire logic           cpu_halt,
  input wire logic           app_read_block,
  input wire logic           irq,
  input wire logic           eeprom_write_busy,
  input wire logic [7:0]     fuse_low_byte,
  input wire logic [7:0]     fuse_high_byte,
  // Flash side
  input wire spf_flash_cmd_t flash_cmd,
  input wire logic           flash_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic start;
  assign start = flash_cmd.erase || flash_cmd.write;

  // ========================================
  // Assertions
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  irq_quiet_a: assert property (
    flash_busy && $past(flash_busy) |-> !irq)
    else $error("interrupt raised while operation runs");
  halt_side_a: assert property (
    start |=> cpu_halt == (flash_cmd.page >= `SPF_BOOT_FIRST_PAGE))
    else $error("halt does not match target section");
  app_block_a: assert property (
    $past(start) && $past(flash_cmd.page) < `SPF_BOOT_FIRST_PAGE
    |-> app_read_block [*4]) else $error("app section not blocked");
  op_span_a: assert property (
    $rose(flash_busy) |-> flash_busy [*8] ##[1:40] !flash_busy)
    else $error("operation length out of bounds");
  no_restart_a: assert property (
    flash_busy && $past(flash_busy) |-> !start)
    else $error("new operation started during busy");
  load_cause_a: assert property (
    cpu_load_taken |-> $past(cpu_req.load) && !$past(eeprom_write_busy))
    else $error("load answered without armed load");
  load_once_a: assert property (
    cpu_load_taken |=> !cpu_load_taken)
    else $error("second load answered on one arming");
  fuse_low_a: assert property (
    cpu_load_taken && $past(cpu_req.ptr) == `SPF_PTR_FUSE_LO
    |-> cpu_load_data == $past(fuse_low_byte))
    else $error("fuse low byte wrong");
  fuse_high_a: assert property (
    cpu_load_taken && $past(cpu_req.ptr) == `SPF_PTR_FUSE_HI
    |-> cpu_load_data == $past(fuse_high_byte))
    else $error("fuse high byte wrong");
  ee_block_a: assert property (
    cpu_req.store && eeprom_write_busy |=> !start)
    else $error("store accepted during eeprom write");

  c_erase: cover property (flash_cmd.erase);
  c_write: cover property (flash_cmd.write);
  c_load: cover property (cpu_load_taken);
  c_irq: cover property ($rose(irq));
endmodule

bind spf_sequencer spf_seq_properties chk_u (
  .core_clk, .resetn, .avs_read, .avs_write, .avs_waitrequest,
  .cpu_req, .cpu_load_taken, .cpu_load_data, .cpu_halt,
  .app_read_block, .irq, .eeprom_write_busy, .fuse_low_byte,
  .fuse_high_byte, .flash_cmd, .flash_busy);
`default_nettype wire

// ### bench/spf_cpu_model.sv
`default_nettype none
module spf_cpu_model
  import spf_pkg::*;
(
  // Clock
  input wire logic         core_clk,
  // Instruction port
  output var spf_cpu_req_t cpu_req,
  input wire logic         cpu_load_taken,
  input wire logic [7:0]   cpu_load_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       got;
  logic [7:0] got_data;

  initial begin
    cpu_req = '0;
    got = 1'b0;
    got_data = 8'h00;
  end

  // returned byte lands in the destination
  always @(posedge core_clk) begin
    if (cpu_load_taken === 1'b1) begin
      got <= 1'b1;
      got_data <= cpu_load_data;
    end
  end

  // issued in the first cycle of the window
  task automatic exec(input logic st, input logic ld,
                      input logic [15:0] p, input logic [15:0] d);
    got = 1'b0;
    cpu_req <= '{store: st, load: ld, ptr: p, data: d};
    @(posedge core_clk);
    // Operands stop holding once the instruction is gone
    cpu_req <= '{store: 1'b0, load: 1'b0, ptr: ~p, data: ~d};
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`include "spf_map.svh"
`default_nettype none
module tb_top
  import spf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           core_clk, resetn, por_n, ew_busy, ew_start;
  logic           avs_read, avs_write, avs_waitrequest, irq;
  logic           cpu_load_taken, cpu_halt, app_read_block, flash_busy;
  logic [3:0]     avs_address;
  logic [4:0]     buf_idx;
  logic [7:0]     cpu_load_data;
  logic [7:0]     fuse_lo, fuse_hi, lock_ini;
  logic [15:0]    buf_word;
  logic [31:0]    avs_writedata, avs_readdata, q;
  spf_cpu_req_t   cpu_req;
  spf_flash_cmd_t flash_cmd;
  int             n_fail, checks_done, cyc_cnt;

  spf_sequencer #(.PAGE_WORDS(32), .OP_CYCLES(20)) dut_u (
    .core_clk(core_clk), .resetn(resetn), .por_n(por_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req),
    .cpu_load_taken(cpu_load_taken), .cpu_load_data(cpu_load_data),
    .cpu_halt(cpu_halt), .app_read_block(app_read_block), .irq(irq),
    .eeprom_write_busy(ew_busy), .eeprom_write_start(ew_start),
    .fuse_low_byte(fuse_lo), .fuse_high_byte(fuse_hi),
    .lock_init(lock_ini),
    .flash_cmd(flash_cmd), .flash_busy(flash_busy),
    .buf_idx(buf_idx), .buf_word(buf_word));

  spf_cpu_model cpu_u (.core_clk(core_clk), .cpu_req(cpu_req),
    .cpu_load_taken(cpu_load_taken), .cpu_load_data(cpu_load_data));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ========================================
  // Tasks
  task automatic give_verdict;
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic fl(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // control writes only when eeprom idle, bar the two refusal cases
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] d);
    bus(1'b1, `SPF_OFF_CTRL, d);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask

  task automatic spm(input logic [15:0] p, input logic [15:0] d);
    cpu_u.exec(1'b1, 1'b0, p, d);
  endtask

  task automatic lpm(input logic [15:0] p, input logic t,
                     input logic [7:0] e);
    cpu_u.exec(1'b0, 1'b1, p, 16'h0000);
    cyc(3);
    fl(cpu_u.got, t);
    if (t) chk({24'h0, cpu_u.got_data}, {24'h0, e});
  endtask

  task automatic bw(input logic [4:0] i, input logic [15:0] e);
    buf_idx <= i;
    cyc(3);
    chk({16'h0, buf_word}, {16'h0, e});
  endtask

  task automatic idle;
    do @(posedge core_clk); while (flash_busy !== 1'b0);
  endtask

  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt > 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ========================================
  // Sequence
  initial begin
    {resetn, por_n, avs_read, avs_write, ew_busy, ew_start} = 6'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    buf_idx = 5'h00;
    {fuse_lo, fuse_hi, lock_ini} = {8'h5a, 8'hc3, 8'hdf};
    {n_fail, checks_done, cyc_cnt} = {32'h0, 32'h0, 32'h0};
    cyc(4);
    resetn <= 1'b1;
    por_n <= 1'b1;
    cyc(3);
    rdc(`SPF_OFF_CTRL, 8'h00);
    rdc(4'hc, 8'h00);
    wr(8'h27);
    rdc(`SPF_OFF_CTRL, 8'h00);
    wr(8'ha0);
    rdc(`SPF_OFF_CTRL, 8'h80);
    fl(irq, 1'b1);
    wr(8'h81);
    spm(16'h0006, 16'h1234);
    rdc(`SPF_OFF_CTRL, 8'h80);
    bw(5'd3, 16'h1234);
    wr(8'h81);
    spm(16'h0006, 16'h5678);
    bw(5'd3, 16'h1234);
    wr(8'h81);
    cyc(5);
    spm(16'h0008, 16'hbeef);
    rdc(`SPF_OFF_CTRL, 8'h80);
    bw(5'd4, 16'hffff);
    ew_start <= 1'b1;
    cyc(1);
    ew_start <= 1'b0;
    bw(5'd3, 16'hffff);
    wr(8'h83);
    spm(16'h0140, 16'h0000);
    cyc(2);
    fl(app_read_block, 1'b1);
    fl(cpu_halt, 1'b0);
    fl(irq, 1'b0);
    rdc(`SPF_OFF_CTRL, 8'hc3);
    rdc(`SPF_OFF_STAT, 8'h01);
    idle();
    cyc(2);
    rdc(`SPF_OFF_CTRL, 8'hc0);
    fl(irq, 1'b1);
    fl(app_read_block, 1'b1);
    wr(8'h91);
    spm(16'h0000, 16'h0000);
    cyc(2);
    fl(app_read_block, 1'b0);
    wr(8'h03);
    spm(16'h1840, 16'h0000);
    cyc(2);
    fl(cpu_halt, 1'b1);
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    cyc(4);
    fl(flash_busy, 1'b1);
    idle();
    cyc(3);
    fl(cpu_halt, 1'b0);
    wr(8'h01);
    spm(16'h0004, 16'ha5a5);
    bw(5'd2, 16'ha5a5);
    wr(8'h05);
    spm(16'h0140, 16'h0000);
    cyc(2);
    fl(cpu_halt, 1'b0);
    idle();
    cyc(2);
    bw(5'd2, 16'hffff);
    wr(8'h01);
    spm(16'h0000, 16'hffff);
    cyc(2);
    fl(app_read_block, 1'b0);
    rdc(`SPF_OFF_LOCK, 8'hdf);
    wr(8'h09);
    spm(16'h0001, 16'h00f3);
    cyc(2);
    fl(app_read_block, 1'b0);
    rdc(`SPF_OFF_LOCK, 8'hd3);
    wr(8'h09);
    lpm(`SPF_PTR_LOCK, 1'b1, 8'hd3);
    rdc(`SPF_OFF_CTRL, 8'h00);
    wr(8'h09);
    lpm(`SPF_PTR_FUSE_LO, 1'b1, 8'h5a);
    wr(8'h09);
    lpm(`SPF_PTR_FUSE_HI, 1'b1, 8'hc3);
    ew_busy <= 1'b1;
    wr(8'h09);
    lpm(`SPF_PTR_FUSE_LO, 1'b0, 8'h00);
    wr(8'h03);
    spm(16'h0140, 16'h0000);
    cyc(2);
    fl(flash_busy, 1'b0);
    ew_busy <= 1'b0;
    wr(8'h09);
    cyc(4);
    lpm(`SPF_PTR_FUSE_LO, 1'b0, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
